// >>> hw/tws_pkg.sv
package tws_pkg;
   localparam int unsigned ADDR_W      = 16;
   localparam int unsigned DATA_W      = 8;
   localparam logic [3:0]  BYTE_BITS   = 4'h8;
   localparam logic [3:0]  LAST_TX_BIT = 4'h7;
   localparam logic [6:0]  DEV_ADDR_DEF = 7'h3c;  // Arbitrary
   localparam logic        DIR_WRITE   = 1'h0;
   localparam logic        DIR_READ    = 1'h1;

   typedef enum logic [2:0] {
      TWS_IDLE = 3'h0,
      TWS_RX   = 3'h1,
      TWS_ACK  = 3'h3,
      TWS_TX   = 3'h2,
      TWS_RACK = 3'h6
   } tws_state_t;

   typedef enum logic [1:0] {
      PH_DEV  = 2'h0,
      PH_HI   = 2'h1,
      PH_LO   = 2'h3,
      PH_DATA = 2'h2
   } tws_phase_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } tws_wr_t;

   typedef struct packed {
      logic o;
      logic oe_n;
   } tws_drv_t;
endpackage

// >>> hw/tws_slave.sv
`timescale 1ns/1ps
// Contract
// - A random-address read opens with a write of the register address, then a restart and the read address byte.
// - A current-address read sends the read address byte right after start and uses the held register pointer.
// - After the write address byte the register address comes high byte then low byte into the pointer.
// - A sequential write continues with data bytes stored at successive addresses until stop.
// - The register pointer advances by one after every 8-bit data transfer, read or write.
// - The last address bit gives direction (0 write, 1 read) and only a matching address is acknowledged.
// - The device acknowledges each register-address byte and each write data byte by pulling data low.
// - A read ends with a master no-acknowledge and stop, and the device releases data on the no-acknowledge.
module tws_slave #(
   parameter logic [6:0] DEV_ADDR = tws_pkg::DEV_ADDR_DEF  // Arbitrary default
) (
   input  wire logic                        sys_clk,
   input  wire logic                        rstn,
   input  wire logic                        scl_i,
   input  wire logic                        sda_i,
   output logic                             sda_o,
   output logic                             sda_oe_n,
   input  wire logic [tws_pkg::DATA_W-1:0]  rd_data,
   output logic [tws_pkg::ADDR_W-1:0]       reg_addr,
   output tws_pkg::tws_wr_t                 reg_wr,
   output logic                             reg_wr_en
);
   logic                         scl_s1, scl_s2, scl_d;
   logic                         sda_s1, sda_s2, sda_d;
   logic                         scl_rise, scl_fall, bus_start, bus_stop;

   tws_pkg::tws_state_t          state, next_state;
   tws_pkg::tws_phase_t          phase, next_phase;
   logic [3:0]                   cnt, next_cnt;
   logic [7:0]                   shift, next_shift;
   logic                         rw, next_rw;
   logic [tws_pkg::ADDR_W-1:0]   ptr, next_ptr;
   tws_pkg::tws_wr_t             next_reg_wr;
   logic                         next_reg_wr_en;
   tws_pkg::tws_drv_t            drv, next_drv;

   assign scl_rise  = scl_s2 & ~scl_d;
   assign scl_fall  = ~scl_s2 & scl_d;
   assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         scl_s1 <= 1'h1;
         scl_s2 <= 1'h1;
         scl_d  <= 1'h1;
         sda_s1 <= 1'h1;
         sda_s2 <= 1'h1;
         sda_d  <= 1'h1;
      end else begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   always_comb begin
      next_state     = state;
      next_phase     = phase;
      next_cnt       = cnt;
      next_shift     = shift;
      next_rw        = rw;
      next_ptr       = ptr;
      next_reg_wr    = reg_wr;
      next_reg_wr_en = 1'h0;
      next_drv       = drv;
      if (bus_stop) begin
         next_state = tws_pkg::TWS_IDLE;
         next_drv   = '{o: 1'h1, oe_n: 1'h1};
      end else if (bus_start) begin
         next_state = tws_pkg::TWS_RX;
         next_phase = tws_pkg::PH_DEV;
         next_cnt   = 4'h0;
         next_drv   = '{o: 1'h1, oe_n: 1'h1};
      end else begin
         unique case (state)
            tws_pkg::TWS_IDLE: ;
            tws_pkg::TWS_RX: begin
               if (scl_rise && cnt != tws_pkg::BYTE_BITS) begin
                  next_shift = {shift[6:0], sda_s2};
                  next_cnt   = cnt + 4'h1;
               end else if (scl_fall && cnt == tws_pkg::BYTE_BITS) begin
                  next_state = tws_pkg::TWS_ACK;
                  next_drv   = '{o: 1'h0, oe_n: 1'h0};
                  unique case (phase)
                     tws_pkg::PH_DEV: begin
                        next_rw = shift[0];
                        if (shift[7:1] != DEV_ADDR) begin
                           next_state = tws_pkg::TWS_IDLE;
                           next_drv   = '{o: 1'h1, oe_n: 1'h1};
                        end
                     end
                     tws_pkg::PH_HI: next_ptr[15:8] = shift;
                     tws_pkg::PH_LO: next_ptr[7:0]  = shift;
                     tws_pkg::PH_DATA: begin
                        next_reg_wr    = '{addr: ptr, data: shift};
                        next_reg_wr_en = 1'h1;
                        next_ptr       = ptr + 16'h1;
                     end
                  endcase
               end
            end
            tws_pkg::TWS_ACK: begin
               if (scl_fall) begin
                  next_cnt = 4'h0;
                  if (phase == tws_pkg::PH_DEV && rw == tws_pkg::DIR_READ) begin
                     next_state = tws_pkg::TWS_TX;
                     next_shift = rd_data;
                     next_drv   = '{o: rd_data[7], oe_n: rd_data[7]};
                  end else begin
                     next_state = tws_pkg::TWS_RX;
                     next_drv   = '{o: 1'h1, oe_n: 1'h1};
                     unique case (phase)
                        tws_pkg::PH_DEV:  next_phase = tws_pkg::PH_HI;
                        tws_pkg::PH_HI:   next_phase = tws_pkg::PH_LO;
                        tws_pkg::PH_LO:   next_phase = tws_pkg::PH_DATA;
                        tws_pkg::PH_DATA: next_phase = tws_pkg::PH_DATA;
                     endcase
                  end
               end
            end
            tws_pkg::TWS_TX: begin
               if (scl_fall) begin
                  if (cnt == tws_pkg::LAST_TX_BIT) begin
                     next_state = tws_pkg::TWS_RACK;
                     next_drv   = '{o: 1'h1, oe_n: 1'h1};
                     next_ptr   = ptr + 16'h1;
                  end else begin
                     next_cnt   = cnt + 4'h1;
                     next_shift = {shift[6:0], 1'h0};
                     next_drv   = '{o: shift[6], oe_n: shift[6]};
                  end
               end
            end
            tws_pkg::TWS_RACK: begin
               if (scl_rise && sda_s2) begin
                  next_state = tws_pkg::TWS_IDLE;
               end else if (scl_fall) begin
                  next_state = tws_pkg::TWS_TX;
                  next_cnt   = 4'h0;
                  next_shift = rd_data;
                  next_drv   = '{o: rd_data[7], oe_n: rd_data[7]};
               end
            end
            default: begin
               next_state = tws_pkg::TWS_IDLE;
               next_drv   = '{o: 1'h1, oe_n: 1'h1};
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state     <= tws_pkg::TWS_IDLE;
         phase     <= tws_pkg::PH_DEV;
         cnt       <= 4'h0;
         shift     <= 8'h0;
         rw        <= tws_pkg::DIR_WRITE;
         ptr       <= 16'h0;
         reg_wr    <= '0;
         reg_wr_en <= 1'h0;
         drv       <= '{o: 1'h1, oe_n: 1'h1};
      end else begin
         state     <= next_state;
         phase     <= next_phase;
         cnt       <= next_cnt;
         shift     <= next_shift;
         rw        <= next_rw;
         ptr       <= next_ptr;
         reg_wr    <= next_reg_wr;
         reg_wr_en <= next_reg_wr_en;
         drv       <= next_drv;
      end
   end

   assign sda_o    = drv.o;
   assign sda_oe_n = drv.oe_n;
   assign reg_addr = ptr;

   a_ack_addr_data: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state == tws_pkg::TWS_RX && scl_fall && cnt == tws_pkg::BYTE_BITS && phase != tws_pkg::PH_DEV
       && !bus_stop && !bus_start) |=> (!sda_oe_n && !sda_o && state == tws_pkg::TWS_ACK))
      else $error("no acknowledge after received byte");
   a_dev_mismatch: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state == tws_pkg::TWS_RX && scl_fall && cnt == tws_pkg::BYTE_BITS && phase == tws_pkg::PH_DEV
       && shift[7:1] != DEV_ADDR && !bus_stop && !bus_start) |=> (state == tws_pkg::TWS_IDLE && sda_oe_n))
      else $error("foreign address was acknowledged");
   a_dev_match: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state == tws_pkg::TWS_RX && scl_fall && cnt == tws_pkg::BYTE_BITS && phase == tws_pkg::PH_DEV
       && shift[7:1] == DEV_ADDR && !bus_stop && !bus_start)
      |=> (state == tws_pkg::TWS_ACK && !sda_oe_n && !sda_o && rw == $past(shift[0])))
      else $error("own address not acknowledged");
   a_write_strobe: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state == tws_pkg::TWS_RX && scl_fall && cnt == tws_pkg::BYTE_BITS && phase == tws_pkg::PH_DATA
       && !bus_stop && !bus_start)
      |=> (reg_wr_en && reg_wr.addr == $past(ptr) && reg_wr.data == $past(shift)))
      else $error("write strobe missing or wrong");
   a_stop_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
      bus_stop |=> (state == tws_pkg::TWS_IDLE && sda_oe_n && ptr == $past(ptr)))
      else $error("stop did not idle or pointer moved");
   a_write_incr: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_wr_en |-> (reg_addr == reg_wr.addr + 16'h1))
      else $error("pointer not advanced after write");
   a_nack_release: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state == tws_pkg::TWS_RACK && scl_rise && sda_s2 && !bus_stop && !bus_start)
      |=> (sda_oe_n && state == tws_pkg::TWS_IDLE) [*2])
      else $error("data not released on no-acknowledge");
   a_hi_byte: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state == tws_pkg::TWS_RX && scl_fall && cnt == tws_pkg::BYTE_BITS && phase == tws_pkg::PH_HI
       && !bus_stop && !bus_start) |=> (ptr[15:8] == $past(shift)))
      else $error("high address byte not loaded");
   a_read_start: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state == tws_pkg::TWS_ACK && scl_fall && phase == tws_pkg::PH_DEV && rw && !bus_stop && !bus_start)
      |=> (state == tws_pkg::TWS_TX && sda_oe_n == $past(rd_data[7])))
      else $error("read did not start from pointer");
   a_read_incr: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state == tws_pkg::TWS_TX && scl_fall && cnt == tws_pkg::LAST_TX_BIT && !bus_stop && !bus_start)
      |=> (ptr == $past(ptr) + 16'h1 && state == tws_pkg::TWS_RACK && sda_oe_n))
      else $error("pointer not advanced after read byte");
endmodule // tws_slave

// >>> test/tws_master.sv
`timescale 1ns/1ps
module tws_master (
   input  wire logic       sys_clk,
   input  wire logic       sda,
   output logic            scl,
   output logic            sda_low,
   output logic [7:0]      rx
);
   event rx_ev;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      rx = 8'h00;
   end
   task automatic step(input logic c, input logic d, input int n);
      scl = c;
      sda_low = ~d;
      repeat (n) @(negedge sys_clk);
   endtask
   // Start, or repeated start from a low clock phase
   task automatic start();
      step(scl, 1'b1, 3);
      step(1'b1, 1'b1, 4);
      step(1'b1, 1'b0, 4);
      step(1'b0, 1'b0, 1);
   endtask
   task automatic stop();
      step(1'b0, 1'b0, 3);
      step(1'b1, 1'b0, 4);
      step(1'b1, 1'b1, 4);
   endtask
   // Data set while clock low, sampled at end of high phase
   task automatic bit_x(input logic b, output logic r);
      step(1'b0, b, 3);
      step(1'b1, b, 4);
      r = sda;
      step(1'b0, b, 1);
   endtask
   task automatic byte_w(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, ack);
   endtask
   // Ack keeps the burst going, no-ack ends it
   task automatic byte_r(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, d[i]);
      end
      bit_x(last, r);
      rx = d;
      ->rx_ev;
   endtask
endmodule // tws_master

// >>> test/tws_slave_tb.sv
`timescale 1ns/1ps
module tws_slave_tb;
   localparam logic [6:0] DEV = 7'h2b; // Arbitrary
   logic             sys_clk, rstn, scl, sda, sda_low, sda_o, sda_oe_n, reg_wr_en, r;
   logic [7:0]       rd_data, rx, key, d;
   logic [15:0]      reg_addr, a, p;
   tws_pkg::tws_wr_t reg_wr;
   logic [23:0]      exp_q[$];
   int               fails, n_tests, seed;
   assign sda = ~(sda_low | (~sda_oe_n & ~sda_o));
   assign rd_data = reg_addr[7:0] ^ reg_addr[15:8] ^ key;
   tws_slave #(.DEV_ADDR(DEV)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .rd_data(rd_data), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wr_en(reg_wr_en));
   tws_master i_mst (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low), .rx(rx));
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic take(input logic [23:0] g);
      chk(g, exp_q.size() > 0 ? exp_q.pop_front() : 24'hxxxxxx);
   endtask
   task automatic wrap_up();
      if (fails == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic addr_ph(input logic [6:0] dv, input logic dir, input logic ack);
      i_mst.start();
      i_mst.byte_w({dv, dir}, r);
      chk(24'(r), 24'(ack));
   endtask
   task automatic set_ptr(input logic [15:0] ad);
      addr_ph(DEV, tws_pkg::DIR_WRITE, 1'b0);
      i_mst.byte_w(ad[15:8], r);
      chk(24'(r), 24'h0);
      i_mst.byte_w(ad[7:0], r);
      chk(24'(r), 24'h0);
      chk(24'(reg_addr), 24'(ad));
      p = ad;
   endtask
   task automatic wr(input logic [15:0] ad, input int n);
      set_ptr(ad);
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         exp_q.push_back({p, d});
         p++;
         i_mst.byte_w(d, r);
         chk(24'(r), 24'h0);
      end
      i_mst.stop();
      chk(24'(reg_addr), 24'(p));
   endtask
   task automatic rd(input int n);
      for (int i = 0; i < n; i++) begin
         exp_q.push_back({16'h0, p[7:0] ^ p[15:8] ^ key});
         p++;
         i_mst.byte_r(i == n - 1, d);
      end
      i_mst.stop();
      chk(24'(sda_oe_n), 24'h1);
      chk(24'(reg_addr), 24'(p));
   endtask
   always @(negedge sys_clk) if (reg_wr_en === 1'b1) take(reg_wr);
   always @(i_mst.rx_ev) take({16'h0, rx});
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      #1000000;
      fails++;
      wrap_up();
   end
   initial begin
      seed = 32'h6a9d;
      key = 8'($random(seed));
      rstn = 1'b0;
      repeat (8) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk({7'h0, sda_oe_n, reg_addr}, 24'h010000);
      for (int k = 0; k < 4; k++) begin
         a = (k == 3) ? 16'hfffe : 16'($random(seed));
         wr(a, k + 1);
         set_ptr(a);
         addr_ph(DEV, tws_pkg::DIR_READ, 1'b0);
         rd(k + 1);
         addr_ph(DEV, tws_pkg::DIR_READ, 1'b0);
         rd(2);
      end
      addr_ph(DEV ^ 7'h01, tws_pkg::DIR_WRITE, 1'b1);
      i_mst.stop();
      addr_ph(DEV, tws_pkg::DIR_READ, 1'b0);
      rd(1);
      // Reset in mid-run clears the pointer
      rstn = 1'b0;
      repeat (8) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk({7'h0, sda_oe_n, reg_addr}, 24'h010000);
      p = 16'h0;
      addr_ph(DEV, tws_pkg::DIR_READ, 1'b0);
      rd(1);
      repeat (20) @(negedge sys_clk);
      chk(24'(exp_q.size()), 24'h0);
      wrap_up();
   end
endmodule // tws_slave_tb
